/* File: fts_consts.vh */
// register offsets, field positions, reset values and codes for the trigger select and mask bank
`ifndef FTS_CONSTS_VH
`define FTS_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define FTS_OFS_MOD_ACT      8'h45
`define FTS_OFS_MASK_LOW     8'h46
`define FTS_OFS_MASK_MID     8'h47
`define FTS_OFS_MASK_HIGH    8'h48

// ----------------------------------------
// reset values
// ----------------------------------------
`define FTS_RST_MOD_ACT      8'h00
`define FTS_RST_MASK_LOW     8'h00
`define FTS_RST_MASK_MID     8'h00
`define FTS_RST_MASK_HIGH    8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define FTS_MOD_ACT_LSB      0
`define FTS_MOD_ACT_MSB      1
`define FTS_PINS_PER_REG     4
`define FTS_NUM_PINS         10
`define FTS_UNMAPPED_RDATA   8'h00
`define FTS_MASK_SEL         1'h0
`define FTS_LEVEL_SEL        1'h1

// ----------------------------------------
// moderate fault action codes
// ----------------------------------------
`define FTS_ACT_IMMEDIATE    2'h0
`define FTS_ACT_ORDERLY      2'h1
`define FTS_ACT_MCU_PWR_ERR  2'h2
`define FTS_ACT_SOC_PWR_ERR  2'h3

`endif

/* File: fts_pin_gate.v */
// per-pin trigger gate: passes pin level or forces the masked level
`timescale 1ns/1ps
`default_nettype none
module fts_pin_gate (
  // pin and settings
  input  wire pin_level,
  input  wire seq_block,
  input  wire seq_block_level,
  // to sequencer
  output wire trig_level
);
  // ----------------------------------------
  // gate
  // ----------------------------------------
  assign trig_level = seq_block ? seq_block_level : pin_level;
endmodule
`default_nettype wire

/* File: fts_sync2.v */
// two flip-flop synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module fts_sync2 #(
  parameter W = 10
) (
  // clock and reset
  input  wire         clk,
  input  wire         rstn,
  // data
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // ----------------------------------------
  // two stages; only the second stage is read
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

/* File: fts_trigger_bank.v */
// trigger select and pin trigger mask register bank
//
// Summary of operation
// - moderate fault action field, four action codes
// - action register 0x45, reset zero, upper bits kept
// - field defaults load from non-volatile memory
// - set mask bit blocks the pin level
// - masked with level clear gives zero
// - masked with level set gives one
// - 0x46 holds pins 1-4, mask then level
// - 0x47 holds pins 5-8, same pairing
// - 0x48 holds remaining pins, reset zero
`timescale 1ns/1ps
`default_nettype none
`include "fts_consts.vh"
module fts_trigger_bank (
  // clock and reset
  input  wire        clk,
  input  wire        rstn,
  // configuration port
  input  wire        cfg_wr,
  input  wire        cfg_rd,
  input  wire [7:0]  cfg_addr,
  input  wire [7:0]  cfg_wdata,
  output wire [7:0]  cfg_rdata,
  output wire        cfg_hit,
  // non-volatile default load
  input  wire        nvm_load,
  input  wire [7:0]  nvm_mod_act,
  input  wire [7:0]  nvm_mask_low,
  input  wire [7:0]  nvm_mask_mid,
  input  wire [7:0]  nvm_mask_high,
  // pins and sequencer side
  input  wire [9:0]  pin_in,
  output wire [9:0]  seq_trig,
  output wire [1:0]  moderate_fault_action,
  output wire        act_immediate,
  output wire        act_orderly,
  output wire        act_mcu_pwr_err,
  output wire        act_soc_pwr_err
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [7:0] moderate_error_action_select_q;
  reg  [7:0] moderate_error_action_select_d;
  reg  [7:0] pin_trigger_mask_low_q;
  reg  [7:0] pin_trigger_mask_low_d;
  reg  [7:0] pin_trigger_mask_mid_q;
  reg  [7:0] pin_trigger_mask_mid_d;
  reg  [7:0] pin_trigger_mask_high_q;
  reg  [7:0] pin_trigger_mask_high_d;
  reg  [7:0] rdata_q;
  reg  [7:0] rdata_d;
  wire [9:0] pin_sync;
  wire       wr_mod_act;
  wire       wr_mask_low;
  wire       wr_mask_mid;
  wire       wr_mask_high;

  // ----------------------------------------
  // per-pin mask and forced level fields
  // ----------------------------------------
  wire       pin1_seq_block;
  wire       pin1_seq_block_level;
  wire       pin2_seq_block;
  wire       pin2_seq_block_level;
  wire       pin3_seq_block;
  wire       pin3_seq_block_level;
  wire       pin4_seq_block;
  wire       pin4_seq_block_level;
  wire       pin5_seq_block;
  wire       pin5_seq_block_level;
  wire       pin6_seq_block;
  wire       pin6_seq_block_level;
  wire       pin7_seq_block;
  wire       pin7_seq_block_level;
  wire       pin8_seq_block;
  wire       pin8_seq_block_level;
  wire       pin9_seq_block;
  wire       pin9_seq_block_level;
  wire       pin10_seq_block;
  wire       pin10_seq_block_level;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function ofs_hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      ofs_hit = (a == ofs);
    end
  endfunction

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = ofs_hit(a, `FTS_OFS_MOD_ACT) | ofs_hit(a, `FTS_OFS_MASK_LOW) |
                  ofs_hit(a, `FTS_OFS_MASK_MID) | ofs_hit(a, `FTS_OFS_MASK_HIGH);
    end
  endfunction

  assign cfg_hit = (cfg_wr | cfg_rd) & is_mapped(cfg_addr);

  // ----------------------------------------
  // strobe qualification
  // ----------------------------------------
  // the default load owns the bank for its cycle, so a write beside it
  // is dropped rather than merged into the loaded value
  assign wr_mod_act   = cfg_wr & ~nvm_load & ofs_hit(cfg_addr, `FTS_OFS_MOD_ACT);
  assign wr_mask_low  = cfg_wr & ~nvm_load & ofs_hit(cfg_addr, `FTS_OFS_MASK_LOW);
  assign wr_mask_mid  = cfg_wr & ~nvm_load & ofs_hit(cfg_addr, `FTS_OFS_MASK_MID);
  assign wr_mask_high = cfg_wr & ~nvm_load & ofs_hit(cfg_addr, `FTS_OFS_MASK_HIGH);

  // ----------------------------------------
  // next register values
  // ----------------------------------------
  // the nvm load wins over a software write in the same cycle, so a
  // reload always leaves the bank in a known default state
  always @* begin
    moderate_error_action_select_d = moderate_error_action_select_q;
    if (nvm_load) begin
      moderate_error_action_select_d = nvm_mod_act;
    end else if (wr_mod_act) begin
      moderate_error_action_select_d = cfg_wdata;
    end
  end

  always @* begin
    pin_trigger_mask_low_d = pin_trigger_mask_low_q;
    if (nvm_load) begin
      pin_trigger_mask_low_d = nvm_mask_low;
    end else if (wr_mask_low) begin
      pin_trigger_mask_low_d = cfg_wdata;
    end
  end

  always @* begin
    pin_trigger_mask_mid_d = pin_trigger_mask_mid_q;
    if (nvm_load) begin
      pin_trigger_mask_mid_d = nvm_mask_mid;
    end else if (wr_mask_mid) begin
      pin_trigger_mask_mid_d = cfg_wdata;
    end
  end

  // upper nibble is plain storage: kept and read back, drives nothing
  always @* begin
    pin_trigger_mask_high_d = pin_trigger_mask_high_q;
    if (nvm_load) begin
      pin_trigger_mask_high_d = nvm_mask_high;
    end else if (wr_mask_high) begin
      pin_trigger_mask_high_d = cfg_wdata;
    end
  end

  // ----------------------------------------
  // register state
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      moderate_error_action_select_q <= `FTS_RST_MOD_ACT;
      pin_trigger_mask_low_q         <= `FTS_RST_MASK_LOW;
      pin_trigger_mask_mid_q         <= `FTS_RST_MASK_MID;
      pin_trigger_mask_high_q        <= `FTS_RST_MASK_HIGH;
    end else begin
      moderate_error_action_select_q <= moderate_error_action_select_d;
      pin_trigger_mask_low_q         <= pin_trigger_mask_low_d;
      pin_trigger_mask_mid_q         <= pin_trigger_mask_mid_d;
      pin_trigger_mask_high_q        <= pin_trigger_mask_high_d;
    end
  end

  // ----------------------------------------
  // read data, registered one cycle after cfg_rd
  // ----------------------------------------
  // the last value is held between reads, so a slow serial front end
  // may pick it up late without issuing a second read
  always @* begin
    rdata_d = rdata_q;
    if (cfg_rd) begin
      case (cfg_addr)
        `FTS_OFS_MOD_ACT:   rdata_d = moderate_error_action_select_q;
        `FTS_OFS_MASK_LOW:  rdata_d = pin_trigger_mask_low_q;
        `FTS_OFS_MASK_MID:  rdata_d = pin_trigger_mask_mid_q;
        `FTS_OFS_MASK_HIGH: rdata_d = pin_trigger_mask_high_q;
        default:            rdata_d = `FTS_UNMAPPED_RDATA;
      endcase
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      rdata_q <= `FTS_UNMAPPED_RDATA;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign cfg_rdata = rdata_q;

  // ----------------------------------------
  // moderate fault action decode
  // ----------------------------------------
  assign moderate_fault_action =
    moderate_error_action_select_q[`FTS_MOD_ACT_MSB:`FTS_MOD_ACT_LSB];
  assign act_immediate   = (moderate_fault_action == `FTS_ACT_IMMEDIATE);
  assign act_orderly     = (moderate_fault_action == `FTS_ACT_ORDERLY);
  assign act_mcu_pwr_err = (moderate_fault_action == `FTS_ACT_MCU_PWR_ERR);
  assign act_soc_pwr_err = (moderate_fault_action == `FTS_ACT_SOC_PWR_ERR);

  // ----------------------------------------
  // pin path
  // ----------------------------------------
  // pins are asynchronous; masked pins still pass the synchroniser,
  // so a forced level reaches the sequencer without the two-cycle lag
  fts_sync2 #(
    .W (`FTS_NUM_PINS)
  ) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // ----------------------------------------
  // field extraction
  // ----------------------------------------
  // slot k of a mask register: mask at bit 2k, forced level at bit 2k+1
  function field_bit;
    input [7:0] r;
    input [1:0] slot;
    input       sel_level;
    reg   [2:0] pos;
    begin
      pos       = {slot, sel_level};
      field_bit = r[pos];
    end
  endfunction

  assign pin1_seq_block        = field_bit(pin_trigger_mask_low_q, 2'h0, `FTS_MASK_SEL);
  assign pin1_seq_block_level  = field_bit(pin_trigger_mask_low_q, 2'h0, `FTS_LEVEL_SEL);
  assign pin2_seq_block        = field_bit(pin_trigger_mask_low_q, 2'h1, `FTS_MASK_SEL);
  assign pin2_seq_block_level  = field_bit(pin_trigger_mask_low_q, 2'h1, `FTS_LEVEL_SEL);
  assign pin3_seq_block        = field_bit(pin_trigger_mask_low_q, 2'h2, `FTS_MASK_SEL);
  assign pin3_seq_block_level  = field_bit(pin_trigger_mask_low_q, 2'h2, `FTS_LEVEL_SEL);
  assign pin4_seq_block        = field_bit(pin_trigger_mask_low_q, 2'h3, `FTS_MASK_SEL);
  assign pin4_seq_block_level  = field_bit(pin_trigger_mask_low_q, 2'h3, `FTS_LEVEL_SEL);
  assign pin5_seq_block        = field_bit(pin_trigger_mask_mid_q, 2'h0, `FTS_MASK_SEL);
  assign pin5_seq_block_level  = field_bit(pin_trigger_mask_mid_q, 2'h0, `FTS_LEVEL_SEL);
  assign pin6_seq_block        = field_bit(pin_trigger_mask_mid_q, 2'h1, `FTS_MASK_SEL);
  assign pin6_seq_block_level  = field_bit(pin_trigger_mask_mid_q, 2'h1, `FTS_LEVEL_SEL);
  assign pin7_seq_block        = field_bit(pin_trigger_mask_mid_q, 2'h2, `FTS_MASK_SEL);
  assign pin7_seq_block_level  = field_bit(pin_trigger_mask_mid_q, 2'h2, `FTS_LEVEL_SEL);
  assign pin8_seq_block        = field_bit(pin_trigger_mask_mid_q, 2'h3, `FTS_MASK_SEL);
  assign pin8_seq_block_level  = field_bit(pin_trigger_mask_mid_q, 2'h3, `FTS_LEVEL_SEL);
  assign pin9_seq_block        = field_bit(pin_trigger_mask_high_q, 2'h0, `FTS_MASK_SEL);
  assign pin9_seq_block_level  = field_bit(pin_trigger_mask_high_q, 2'h0, `FTS_LEVEL_SEL);
  assign pin10_seq_block       = field_bit(pin_trigger_mask_high_q, 2'h1, `FTS_MASK_SEL);
  assign pin10_seq_block_level = field_bit(pin_trigger_mask_high_q, 2'h1, `FTS_LEVEL_SEL);

  // ----------------------------------------
  // trigger gates, one per pin
  // ----------------------------------------
  fts_pin_gate u_gate_pin1 (
    .pin_level       (pin_sync[0]),
    .seq_block       (pin1_seq_block),
    .seq_block_level (pin1_seq_block_level),
    .trig_level      (seq_trig[0])
  );
  fts_pin_gate u_gate_pin2 (
    .pin_level       (pin_sync[1]),
    .seq_block       (pin2_seq_block),
    .seq_block_level (pin2_seq_block_level),
    .trig_level      (seq_trig[1])
  );
  fts_pin_gate u_gate_pin3 (
    .pin_level       (pin_sync[2]),
    .seq_block       (pin3_seq_block),
    .seq_block_level (pin3_seq_block_level),
    .trig_level      (seq_trig[2])
  );
  fts_pin_gate u_gate_pin4 (
    .pin_level       (pin_sync[3]),
    .seq_block       (pin4_seq_block),
    .seq_block_level (pin4_seq_block_level),
    .trig_level      (seq_trig[3])
  );
  fts_pin_gate u_gate_pin5 (
    .pin_level       (pin_sync[4]),
    .seq_block       (pin5_seq_block),
    .seq_block_level (pin5_seq_block_level),
    .trig_level      (seq_trig[4])
  );
  fts_pin_gate u_gate_pin6 (
    .pin_level       (pin_sync[5]),
    .seq_block       (pin6_seq_block),
    .seq_block_level (pin6_seq_block_level),
    .trig_level      (seq_trig[5])
  );
  fts_pin_gate u_gate_pin7 (
    .pin_level       (pin_sync[6]),
    .seq_block       (pin7_seq_block),
    .seq_block_level (pin7_seq_block_level),
    .trig_level      (seq_trig[6])
  );
  fts_pin_gate u_gate_pin8 (
    .pin_level       (pin_sync[7]),
    .seq_block       (pin8_seq_block),
    .seq_block_level (pin8_seq_block_level),
    .trig_level      (seq_trig[7])
  );
  fts_pin_gate u_gate_pin9 (
    .pin_level       (pin_sync[8]),
    .seq_block       (pin9_seq_block),
    .seq_block_level (pin9_seq_block_level),
    .trig_level      (seq_trig[8])
  );
  fts_pin_gate u_gate_pin10 (
    .pin_level       (pin_sync[9]),
    .seq_block       (pin10_seq_block),
    .seq_block_level (pin10_seq_block_level),
    .trig_level      (seq_trig[9])
  );

endmodule
`default_nettype wire

/* File: fts_trigger_bank_properties.sv */
// assertion checker for the trigger select and mask bank
`timescale 1ns/1ps
`default_nettype none
module fts_trigger_bank_properties (
  // clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // configuration port
  input wire logic       cfg_wr,
  input wire logic       cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic       cfg_hit,
  // defaults and sequencer side
  input wire logic       nvm_load,
  input wire logic [7:0] nvm_mod_act,
  input wire logic [9:0] seq_trig,
  input wire logic [1:0] moderate_fault_action,
  input wire logic       act_immediate,
  input wire logic       act_orderly,
  input wire logic       act_mcu_pwr_err,
  input wire logic       act_soc_pwr_err
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // a write beside a default load is lost, so it must not arm the checks
  wire wr_ok = cfg_wr && !nvm_load;
  sequence s_wr_rd;
    wr_ok && cfg_hit ##1 cfg_rd && cfg_addr == $past(cfg_addr);
  endsequence
  AST_ONEHOT: assert property ({act_soc_pwr_err, act_mcu_pwr_err, act_orderly,
    act_immediate} == 4'h1 << moderate_fault_action) else $error("action decode");
  AST_ACT_WR: assert property (wr_ok && cfg_addr == 8'h45 |=>
    moderate_fault_action == $past(cfg_wdata[1:0])) else $error("action write");
  AST_NVM: assert property (nvm_load |=>
    moderate_fault_action == $past(nvm_mod_act[1:0])) else $error("default load");
  AST_UNMAP: assert property (cfg_rd && !cfg_hit |=> cfg_rdata == 8'h00)
    else $error("unmapped read");
  AST_HIT: assert property (cfg_wr || cfg_rd |->
    cfg_hit == (cfg_addr >= 8'h45 && cfg_addr <= 8'h48)) else $error("decode");
  AST_LVL1: assert property (wr_ok && cfg_addr == 8'h46 && cfg_wdata[1:0] == 2'h3
    |=> seq_trig[0]) else $error("forced one");
  AST_LVL0: assert property (wr_ok && cfg_addr == 8'h47 && cfg_wdata[7:6] == 2'h1
    |=> !seq_trig[7]) else $error("forced zero");
  AST_RDBACK: assert property (s_wr_rd |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("read back");
endmodule
bind fts_trigger_bank fts_trigger_bank_properties u_chk (.clk, .rstn, .cfg_wr, .cfg_rd,
  .cfg_addr, .cfg_wdata, .cfg_rdata, .cfg_hit, .nvm_load, .nvm_mod_act, .seq_trig,
  .moderate_fault_action, .act_immediate, .act_orderly, .act_mcu_pwr_err, .act_soc_pwr_err);
`default_nettype wire

/* File: fts_trigger_bank_tb.sv */
// self-checking bench for the trigger select and mask bank
`timescale 1ns/1ps
`default_nettype none
module fts_trigger_bank_tb;
  logic       clk = 1'b0, rstn = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, nvm_load = 1'b0;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata, d;
  logic [7:0] nv [0:3];
  logic [7:0] m [0:3];
  logic [9:0] pin_in = 10'h000, seq_trig;
  logic [1:0] mfa;
  logic [3:0] act;
  logic       cfg_hit;
  int         fail_count = 0, checks_done = 0, i;
  initial forever #12.5 clk = ~clk;
  fts_trigger_bank dut (.clk(clk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit),
    .nvm_load(nvm_load), .nvm_mod_act(nv[0]), .nvm_mask_low(nv[1]), .nvm_mask_mid(nv[2]),
    .nvm_mask_high(nv[3]), .pin_in(pin_in), .seq_trig(seq_trig),
    .moderate_fault_action(mfa), .act_immediate(act[0]), .act_orderly(act[1]),
    .act_mcu_pwr_err(act[2]), .act_soc_pwr_err(act[3]));
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // strobes stand until the next task or idle, so back-to-back calls never
  // assign one strobe twice in a time step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    cfg_wr = 1'b1;
    cfg_rd = 1'b0;
    cfg_addr = a;
    cfg_wdata = v;
    if (a >= 8'h45 && a <= 8'h48) m[a - 8'h45] = v;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    cfg_rd = 1'b1;
    cfg_wr = 1'b0;
    cfg_addr = a;
    @(negedge clk);
    v = cfg_rdata;
    chk({9'h000, cfg_hit}, {9'h000, (a >= 8'h45 && a <= 8'h48)});
  endtask
  task automatic idle;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    @(negedge clk);
  endtask
  // masked pins take the level bit, open pins pass the synchronised level
  function automatic logic [9:0] exp_trig(input logic [9:0] p);
    logic [1:0] f;
    for (int n = 0; n < 10; n++) begin
      f = 2'(m[1 + n / 4] >> (2 * (n % 4)));
      exp_trig[n] = f[0] ? f[1] : p[n];
    end
  endfunction
  task automatic chk_all;
    idle;
    repeat (2) @(negedge clk);
    chk(seq_trig, exp_trig(pin_in));
    chk({6'h00, act}, 10'h1 << m[0][1:0]);
    for (int k = 0; k < 4; k++) begin
      rd(8'(8'h45 + k), d);
      chk({2'h0, d}, {2'h0, m[k]});
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    foreach (m[k]) m[k] = 8'h00;
    foreach (nv[k]) nv[k] = 8'h00;
    void'($urandom(32'h833B8038));
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    chk_all;
    wr(8'h44, 8'hFF);
    wr(8'h49, 8'hFF);
    rd(8'h49, d);
    chk({2'h0, d}, 10'h000);
    chk_all;
    $display("test reset and unmapped done");
    for (i = 0; i < 4; i++) begin
      wr(8'h45, {6'h3F, 2'(i)});
      chk_all;
    end
    pin_in = 10'h3FF;
    wr(8'h46, 8'h03);
    wr(8'h47, 8'h40);
    wr(8'h48, 8'h0E);
    chk_all;
    $display("test codes and corners done");
    for (i = 0; i < 30; i++) begin
      pin_in = 10'($urandom);
      wr(8'(8'h45 + $urandom % 4), 8'($urandom));
      rd(cfg_addr, d);
      chk({2'h0, d}, {2'h0, m[cfg_addr - 8'h45]});
      chk_all;
    end
    $display("test random done");
    // a write landing with the default load must be lost
    foreach (nv[k]) nv[k] = 8'($urandom);
    nvm_load = 1'b1;
    wr(8'h46, ~nv[1]);
    nvm_load = 1'b0;
    foreach (m[k]) m[k] = nv[k];
    chk_all;
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    foreach (m[k]) m[k] = 8'h00;
    chk_all;
    $display("test load and reset done");
    end_sim;
  end
endmodule
`default_nettype wire
